// File: src/twem_pkg.sv
// Shared constants, field layouts and carrier types of the three-wire
// EEPROM master. Assumes a single 125 MHz system clock.
package twem_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_KHZ = 125000;
    localparam int SCK_KHZ = 500;
    // Half a serial clock period; 500 kHz at 125 MHz gives 125 cycles
    localparam int HALF_CYC = SYS_CLK_KHZ / (2 * SCK_KHZ);
    localparam int TICK_W = 7;
    localparam logic [TICK_W-1:0] HALF_LAST = TICK_W'(HALF_CYC - 1);

    // ------------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------------
    localparam int CNT_LSB = 0;
    localparam int RD_BIT = 4;
    localparam int HIZ_BIT = 5;
    localparam int BUSY_BIT = 6;
    localparam int WFR_BIT = 7;
    localparam logic [3:0] CNT_MAX = 4'h8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] FUNC_THREE_WIRE = 2'h3;
    localparam logic [2:0] DIV_FULL_RATE = 3'h0;

    // ------------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // Bit order follows the control register layout
    typedef struct packed {
        logic wait_for_ready;
        logic busy;
        logic float_after_last;
        logic rd;
        logic [3:0] cnt;
    } twem_ctrl_t;

    typedef struct packed {
        logic sck;
        logic sd_o;
        logic sd_oe;
    } twem_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_WAIT,
        ST_PUSH
    } twem_state_t;

endpackage : twem_pkg

// File: src/twem_fifo.sv
// Parameterised FIFO with valid/ready on both sides and a registered
// output stage. Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module twem_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } twem_fifo_st_t;

    twem_fifo_st_t q;
    twem_fifo_st_t d;
    logic push;
    logic pop;

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    // Full is honest: the output stage adds one slot beyond D
    assign in_ready = (q.cnt != (AW+1)'(D));
    assign push = in_valid && in_ready;
    assign pop = (q.cnt != '0) && (!q.ov || out_ready);
    assign out_valid = q.ov;
    assign out_data = q.od;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (pop)
        begin
            d.od = q.mem[q.rp];
            d.rp = q.rp + 1'b1;
            d.ov = 1'b1;
        end
        else if (out_ready)
        begin
            d.ov = 1'b0;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

endmodule : twem_fifo

// File: src/twem_master.sv
// Three-wire serial EEPROM master: control and data registers on the
// processor's register port, a serial clock and a shared data line.
// Assumes firmware drives chip select from a general-purpose pin.
//
// Functional notes
// - Serial clock runs at 500 kHz over data line, clock and GPIO select.
// - Pins reach the engine only when pin function select equals 3.
// - Engine works only at processor clock divider 000; other settings refused.
// - Each control write while idle and routed starts one command moving up to 8 bits.
// - Count field bits 3:0 sets clock pulses, legal range 0 to 8.
// - Read captures bits MSB first, right-justified into data register.
// - Write shifts bits out MSB first from top of data register.
// - Zero count gives no clock; data line just follows float bit.
// - Float bit releases data line right after last rising clock edge.
// - Busy bit 6 high during command; its fall raises done interrupt.
// - Wait-for-ready with float holds busy until data line rises.
// - Control and data registers reachable as processor special registers.
`timescale 1ns/1ns
module twem_master
    import twem_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CTRL_WE,
    input wire logic [7:0] CTRL_WDATA,
    output logic [7:0] CTRL_RDATA,
    input wire logic DATA_WE,
    input wire logic [7:0] DATA_WDATA,
    output logic [7:0] DATA_RDATA,
    input wire logic [1:0] PIN_FUNC_SEL,
    input wire logic [2:0] CLK_DIV,
    input wire logic SD_IN,
    output twem_pins_t PINS,
    output logic DONE_IRQ,
    output logic RX_VALID,
    input wire logic RX_READY,
    output logic [7:0] RX_DATA
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        twem_state_t state;
        twem_ctrl_t ctrl;
        logic [3:0] left;
        logic [TICK_W-1:0] tick;
        logic [7:0] shift;
        logic sck;
        logic sd_o;
        logic oe;
        logic sd_prev;
        logic irq;
    } twem_st_t;

    twem_st_t q;
    twem_st_t d;
    twem_ctrl_t wr_ctrl;
    logic busy;
    logic route_ok;
    logic start;
    logic fifo_ready;
    logic push_valid;

    // Engine usable only with the pins routed and at full processor rate
    function automatic logic engine_ok(input logic [1:0] fsel, input logic [2:0] div);
        engine_ok = (fsel == FUNC_THREE_WIRE) && (div == DIV_FULL_RATE);
    endfunction : engine_ok

    // ------------------------------------------------------------------
    // Register port and pins
    // ------------------------------------------------------------------
    assign wr_ctrl = twem_ctrl_t'(CTRL_WDATA);
    assign busy = (q.state != ST_IDLE);
    assign route_ok = engine_ok(PIN_FUNC_SEL, CLK_DIV);
    // Writes while busy are dropped so the transfer finishes intact
    assign start = CTRL_WE && !busy && route_ok;
    assign CTRL_RDATA = {q.ctrl.wait_for_ready, busy, q.ctrl.float_after_last, q.ctrl.rd, q.ctrl.cnt};
    assign DATA_RDATA = q.shift;
    // Pins are parked when another function owns them
    assign PINS.sck = q.sck && route_ok;
    assign PINS.sd_o = q.sd_o;
    assign PINS.sd_oe = q.oe && route_ok;
    assign DONE_IRQ = q.irq;
    assign push_valid = (q.state == ST_PUSH);

    // ------------------------------------------------------------------
    // Engine
    // ------------------------------------------------------------------
    always_comb
    begin
        twem_state_t fin;
        fin = ST_IDLE;
        d = q;
        d.irq = 1'b0;
        d.sd_prev = SD_IN;
        // Where a command goes once its last clock is done
        if (q.ctrl.wait_for_ready && q.ctrl.float_after_last)
            fin = ST_WAIT;
        else if (q.ctrl.rd && q.ctrl.cnt != 4'h0)
            fin = ST_PUSH;
        unique case (q.state)
            ST_IDLE:
            begin
                d.sck = 1'b0;
                if (start)
                begin
                    d.ctrl = wr_ctrl;
                    d.ctrl.busy = 1'b0;
                    // Counts above the limit are clamped to a full byte
                    d.ctrl.cnt = (wr_ctrl.cnt > CNT_MAX) ? CNT_MAX : wr_ctrl.cnt;
                    d.left = d.ctrl.cnt;
                    d.tick = '0;
                    d.state = ST_LOW;
                    if (d.ctrl.cnt == 4'h0)
                        d.oe = !wr_ctrl.float_after_last;
                    else if (!wr_ctrl.rd)
                    begin
                        d.oe = 1'b1;
                        d.sd_o = q.shift[7];
                    end
                end
                else if (DATA_WE)
                begin
                    d.shift = DATA_WDATA;
                end
            end
            ST_LOW:
            begin
                d.tick = q.tick + 1'b1;
                if (q.left == 4'h0)
                begin
                    d.state = fin;
                    d.irq = (fin == ST_IDLE);
                end
                else if (q.tick == HALF_LAST)
                begin
                    d.tick = '0;
                    d.sck = 1'b1;
                    d.state = ST_HIGH;
                end
            end
            ST_HIGH:
            begin
                d.tick = q.tick + 1'b1;
                // Line held over the last rise, released one cycle later for hold time
                if (q.tick == '0 && q.left == 4'h1 && q.ctrl.float_after_last)
                    d.oe = 1'b0;
                if (q.tick == HALF_LAST)
                begin
                    d.tick = '0;
                    d.sck = 1'b0;
                    d.left = q.left - 1'b1;
                    d.state = ST_LOW;
                    // Read samples at the end of the high phase, LSB enters
                    if (q.ctrl.rd)
                        d.shift = {q.shift[6:0], SD_IN};
                    else
                    begin
                        d.shift = {q.shift[6:0], 1'b0};
                        d.sd_o = q.shift[6];
                    end
                end
            end
            ST_WAIT:
            begin
                // Ready shows as a rising data line from the EEPROM
                if (SD_IN && !q.sd_prev)
                begin
                    d.state = (q.ctrl.rd && q.ctrl.cnt != 4'h0) ? ST_PUSH : ST_IDLE;
                    d.irq = !(q.ctrl.rd && q.ctrl.cnt != 4'h0);
                end
            end
            ST_PUSH:
            begin
                // Busy holds while the receive FIFO is full
                if (fifo_ready)
                begin
                    d.state = ST_IDLE;
                    d.irq = 1'b1;
                end
            end
        endcase
    end

    // State register; data line driven after reset
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            q <= '0;
            q.oe <= 1'b1;
        end
        else
            q <= d;
    end

    // ------------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------------
    twem_fifo #(
        .W(DATA_W),
        .D(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .in_valid(push_valid),
        .in_ready(fifo_ready),
        .in_data(q.shift),
        .out_valid(RX_VALID),
        .out_ready(RX_READY),
        .out_data(RX_DATA)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    // Length of the current high phase of the serial clock
    logic [7:0] hi_len;
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || !q.sck)
            hi_len <= 8'h00;
        else
            hi_len <= hi_len + 8'h01;
    end

    half_period_a: assert property ($fell(q.sck) |-> hi_len == 8'(HALF_CYC))
        else $error("serial clock high phase wrong length");
    route_gate_a: assert property (!route_ok |-> !PINS.sck && !PINS.sd_oe)
        else $error("pins driven while not routed");
    div_refuse_a: assert property (!busy && CTRL_WE && CLK_DIV != DIV_FULL_RATE |=> !busy)
        else $error("command started at divided clock");
    start_busy_a: assert property (start |=> busy && q.ctrl.rd == $past(wr_ctrl.rd))
        else $error("control write did not start command");
    zero_count_a: assert property (start && wr_ctrl.cnt == 4'h0 |=> !q.sck [*2])
        else $error("clock issued with zero count");
    float_last_a: assert property ($rose(q.sck) && q.left == 4'h1 && q.ctrl.float_after_last |-> (q.oe || q.ctrl.rd) ##1 !q.oe)
        else $error("data line not floated after last edge");
    busy_irq_a: assert property ($fell(busy) |-> DONE_IRQ)
        else $error("busy fell without interrupt");
    wait_hold_a: assert property (q.state == ST_WAIT && !SD_IN |=> busy)
        else $error("busy fell before ready edge");
    msb_out_a: assert property ($rose(q.sck) && !q.ctrl.rd |-> q.oe && q.sd_o == q.shift[7])
        else $error("write bit not taken from MSB");
    read_in_a: assert property ($fell(q.sck) && q.ctrl.rd |-> q.shift[0] == $past(SD_IN))
        else $error("read bit not captured into LSB");
    ignore_busy_a: assert property (busy && CTRL_WE |=> $stable(q.ctrl))
        else $error("control changed during command");
    idle_clock_a: assert property (!busy |-> !q.sck)
        else $error("serial clock not idle low");

    read_done_c: cover property (q.state == ST_PUSH && fifo_ready);
    wfr_done_c: cover property (q.state == ST_WAIT ##1 DONE_IRQ);
    write_byte_c: cover property (start && !wr_ctrl.rd && wr_ctrl.cnt == CNT_MAX);
    fifo_full_c: cover property (q.state == ST_PUSH && !fifo_ready);

endmodule : twem_master

// File: tb/twem_eeprom_model.sv
// Behavioural three-wire EEPROM for the master's bench.
// Assumes select comes from the bench and the master drives while enabled.
`timescale 1ns/1ns
module twem_eeprom_model #(
    parameter int READY_CYC = 300
) (
    input wire logic clk,
    input wire logic sck,
    input wire logic sd_oe,
    input wire logic sd_o,
    input wire logic cs,
    input wire logic ready_mode,
    input wire logic [7:0] rd_byte,
    output logic sd_line,
    output logic [7:0] got_r
);
    logic sck_q = 1'b0;
    logic pat_r = 1'b0;
    logic [3:0] idx_r = 4'h0;
    int wait_r = 0;

    // Edges seen through the system clock; the master holds its bit over the rise
    always @(posedge clk)
    begin
        sck_q <= sck;
        pat_r <= ~pat_r;
        if (sck && !sck_q)
            got_r <= {got_r[6:0], sd_line};
        if (!cs)
            idx_r <= 4'h0;
        else if (!sck && sck_q)
            idx_r <= idx_r + 4'h1;
        wait_r <= sd_oe ? 0 : wait_r + 1;
    end

    // Line level: master, else wandering when nobody drives, else the memory
    always_comb
    begin
        if (sd_oe)
            sd_line = sd_o;
        else if (!cs)
            sd_line = pat_r;
        else if (ready_mode)
            sd_line = (wait_r >= READY_CYC);
        else
            sd_line = rd_byte[3'(7 - idx_r)];
    end
endmodule : twem_eeprom_model

// File: tb/twem_master_tb.sv
// Self-checking bench for the three-wire EEPROM master.
// Assumes a 125 MHz clock and a bench-driven chip select.
`timescale 1ns/1ns
module twem_master_tb
    import twem_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ctrl_we = 1'b0;
    logic data_we = 1'b0;
    logic rx_ready = 1'b0;
    logic cs = 1'b0;
    logic rdy_mode = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [7:0] data_wdata = 8'h00;
    logic [7:0] rd_byte = 8'h96;
    logic [1:0] pin_func_sel = FUNC_THREE_WIRE;
    logic [2:0] clk_div = DIV_FULL_RATE;
    logic [7:0] ctrl_rdata;
    logic [7:0] data_rdata;
    logic [7:0] rx_data;
    logic [7:0] got;
    logic done_irq;
    logic rx_valid;
    logic sd_line;
    twem_pins_t pins;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int cyc;
    int rises;
    int irqs;
    int k;

    twem_master i_twem_master (
        .CLK_SYS(clk_sys), .RSTN(rstn), .CTRL_WE(ctrl_we), .CTRL_WDATA(ctrl_wdata),
        .CTRL_RDATA(ctrl_rdata), .DATA_WE(data_we), .DATA_WDATA(data_wdata),
        .DATA_RDATA(data_rdata), .PIN_FUNC_SEL(pin_func_sel), .CLK_DIV(clk_div),
        .SD_IN(sd_line), .PINS(pins), .DONE_IRQ(done_irq), .RX_VALID(rx_valid),
        .RX_READY(rx_ready), .RX_DATA(rx_data)
    );
    twem_eeprom_model i_twem_eeprom_model (
        .clk(clk_sys), .sck(pins.sck), .sd_oe(pins.sd_oe), .sd_o(pins.sd_o), .cs(cs),
        .ready_mode(rdy_mode), .rd_byte(rd_byte), .sd_line(sd_line), .got_r(got)
    );

    // Clock and hang guard; the ceiling leaves slack over about 24k cycles
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            $display("ERROR t=%0t run hung", $time);
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR t=%0t %s: got %h exp %h", $time, msg, g, e);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task automatic ld(input logic [7:0] d);
        data_wdata = d;
        data_we = 1'b1;
        @(negedge clk_sys);
        data_we = 1'b0;
    endtask : ld

    // One command; counts clock rises and done pulses until busy drops
    task automatic cmd(input logic [7:0] c, input bit poke);
        logic sck_q;
        sck_q = 1'b0;
        rises = 0;
        irqs = 0;
        cyc = 0;
        ctrl_wdata = c;
        ctrl_we = 1'b1;
        @(negedge clk_sys);
        ctrl_wdata = 8'h13;
        while (cyc < 20000)
        begin
            cyc++;
            ctrl_we = poke && cyc == 10;
            if (pins.sck && !sck_q && !c[4])
                chk(pins.sd_oe, 1, "driven at rise");
            if (pins.sck && !sck_q)
                rises++;
            if (pins.sck && sck_q && rises == c[3:0] && c[5])
                chk(pins.sd_oe, 0, "float");
            sck_q = pins.sck;
            if (done_irq === 1'b1)
                irqs++;
            if (ctrl_rdata[6] !== 1'b1)
                break;
            @(negedge clk_sys);
        end
        // One edge passes so the next strobe is a fresh request
        @(negedge clk_sys);
        chk(ctrl_rdata[6], 0, "command ended");
    endtask : cmd

    task automatic t_reset();
        chk(ctrl_rdata, CTRL_RST, "ctrl reset");
        chk(data_rdata, DATA_RST, "data reset");
        chk(pins, 3'b001, "idle pins");
        $display("reset test done");
    endtask : t_reset

    task automatic t_counts();
        cs = 1'b1;
        for (int n = 0; n <= 8; n++)
        begin
            ld(8'hb4);
            cmd({4'h0, 4'(n)}, n == 8);
            chk(cyc, 2 * HALF_CYC * n + 2, "length");
            chk(rises, n, "clock count");
            chk(irqs, 1, "done pulse");
            chk(got & ((1 << n) - 1), 8'hb4 >> (8 - n), "sent bits");
            chk(ctrl_rdata, {4'h0, 4'(n)}, "ctrl kept");
            chk(pins.sd_oe, 1, "still driven");
        end
        $display("count test done");
    endtask : t_counts

    task automatic t_float();
        cmd(8'h20, 0);
        chk(pins.sd_oe, 0, "zero count float");
        cmd(8'h00, 0);
        chk(pins.sd_oe, 1, "zero count drive");
        ld(8'h3c);
        cmd(8'h28, 0);
        chk(got, 8'h3c, "float write");
        chk(pins.sd_oe, 0, "released");
        rdy_mode = 1'b1;
        cmd(8'ha8, 0);
        // Released one cycle into the last high phase, ready 300 cycles later
        chk(cyc, 2 * HALF_CYC * 8 - HALF_CYC + 1 + 300 + 2, "ready wait");
        chk(irqs, 1, "ready done");
        rdy_mode = 1'b0;
        cmd(8'h00, 0);
        cmd(8'h88, 0);
        chk(cyc, 2 * HALF_CYC * 8 + 2, "wait ignored");
        $display("float test done");
    endtask : t_float

    task automatic t_read();
        cs = 1'b0;
        @(negedge clk_sys);
        cs = 1'b1;
        cmd(8'h20, 0);
        cmd(8'h38, 0);
        chk(data_rdata, 8'h96, "read byte");
        ld(8'h5a);
        cmd(8'h34, 0);
        chk(data_rdata, 8'ha9, "right justified");
        cs = 1'b0;
        cmd(8'h00, 0);
        chk(pins.sd_oe, 1, "line retaken");
        chk(rx_valid, 1, "rx ready");
        chk(rx_data, 8'h96, "rx first");
        // Ready held over two edges: both bytes taken back to back
        rx_ready = 1'b1;
        @(negedge clk_sys);
        chk(rx_valid, 1, "rx next");
        chk(rx_data, 8'ha9, "rx second");
        @(negedge clk_sys);
        rx_ready = 1'b0;
        chk(rx_valid, 0, "rx empty");
        $display("read test done");
    endtask : t_read

    task automatic t_fifo();
        cs = 1'b1;
        cmd(8'h20, 0);
        repeat (17) cmd(8'h31, 0);
        ctrl_wdata = 8'h31;
        ctrl_we = 1'b1;
        @(negedge clk_sys);
        ctrl_we = 1'b0;
        repeat (600) @(negedge clk_sys);
        chk(ctrl_rdata[6], 1, "full holds busy");
        rx_ready = 1'b1;
        k = 0;
        repeat (400)
        begin
            if (rx_valid === 1'b1)
                k++;
            @(negedge clk_sys);
        end
        rx_ready = 1'b0;
        chk(k, 18, "drained");
        chk(ctrl_rdata[6], 0, "busy released");
        cs = 1'b0;
        cmd(8'h00, 0);
        $display("fifo test done");
    endtask : t_fifo

    task automatic t_route();
        pin_func_sel = 2'h1;
        cmd(8'h08, 0);
        chk(cyc, 1, "wrong select start");
        chk(rises, 0, "wrong select clock");
        chk(pins.sd_oe, 0, "wrong select park");
        pin_func_sel = FUNC_THREE_WIRE;
        clk_div = 3'h1;
        cmd(8'h08, 0);
        chk(cyc, 1, "wrong divider start");
        chk(rises, 0, "wrong divider clock");
        chk(pins.sck, 0, "wrong divider park");
        clk_div = DIV_FULL_RATE;
        $display("route test done");
    endtask : t_route

    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_counts();
        t_float();
        t_read();
        t_fifo();
        t_route();
        print_verdict();
    end
endmodule : twem_master_tb
